// file: sap_pkg.sv
// package for the serial audio port
// assumes a byte-wide special-function register bus
package sap_pkg;
    // register indexes
    localparam logic [3:0] ADDR_CFG0 = 4'h0;
    localparam logic [3:0] ADDR_CFG1 = 4'h1;
    localparam logic [3:0] ADDR_DATL = 4'h2;
    localparam logic [3:0] ADDR_DATH = 4'h3;
    localparam logic [3:0] ADDR_CLKF0 = 4'h4;
    localparam logic [3:0] ADDR_CLKF1 = 4'h5;
    localparam logic [3:0] ADDR_CLKF2 = 4'h6;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    // config0 bit positions
    localparam int CFG0_IFACE_ENABLE = 0;
    localparam int CFG0_MASTER = 1;
    localparam int CFG0_RX_SINGLE_CHANNEL = 2;
    localparam int CFG0_TX_SINGLE_CHANNEL = 3;
    localparam int CFG0_CMP = 4;
    localparam int CFG0_EXP = 5;
    localparam int CFG0_RX_DONE_INT_EN = 6;
    localparam int CFG0_TX_DONE_INT_EN = 7;
    // status bit positions
    localparam int ST_RX_DONE_FLAG = 0;
    localparam int ST_TX_DONE_FLAG = 1;
    localparam int ST_RX_OVERFLOW_FLAG = 2;
    localparam int ST_TX_UNDERFLOW_FLAG = 3;
    localparam int ST_RX_CHANNEL_SIDE = 4;
    localparam int ST_TX_CHANNEL_SIDE = 5;
    // reset values: 16-bit words, 44.1 kHz style divider
    localparam logic [7:0] CFG0_RST = 8'h00;
    localparam logic [4:0] WORDS_RST = 5'h0f;
    localparam logic [7:0] CLKF0_RST = 8'h93;
    localparam logic [7:0] CLKF1_RST = 8'he2;
    localparam logic [7:0] CLKF2_RST = 8'h04;
    localparam int SAMPLE_W = 16;
    localparam int DMA_TRIG_RX = 27;
    localparam int DMA_TRIG_TX = 28;
endpackage : sap_pkg

// file: sap_port.sv
// serial audio port: registers, fractional clock divider, tx and rx shifters
// assumes a byte register bus with one-cycle read and write strobes
`timescale 1ns/1ps
module sap_port #(
    parameter int DW = 8
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic [3:0] ADDR_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [DW-1:0] WDATA_I,
    output logic [DW-1:0] RDATA_O,
    input wire logic SYS_TX_INT_EN_I,
    input wire logic SYS_RX_INT_EN_I,
    output logic SYS_TX_INT_FLAG_O,
    output logic SYS_RX_INT_FLAG_O,
    output logic IRQ_O,
    output logic TX_COMPLETE_TRIGGER_O,
    output logic RX_COMPLETE_TRIGGER_O,
    input wire logic SCK_I,
    output logic SCK_O,
    output logic SCK_OE_O,
    input wire logic WS_I,
    output logic WS_O,
    output logic WS_OE_O,
    input wire logic SD_RX_I,
    output logic SD_TX_O
);
    // ==================================================================
    // register state
    logic [7:0] cfg0_r;
    logic [4:0] words_r;
    logic [7:0] clkf0_r, clkf1_r, clkf2_r;
    logic [7:0] datl_w_r, dath_w_r;
    logic [15:0] rx_data_r;
    logic tx_full_r, rx_full_r;
    logic tx_done_flag_r, rx_done_flag_r;
    logic tx_underflow_flag_r, rx_overflow_flag_r;
    logic tx_channel_side_r, rx_channel_side_r;
    logic [7:0] stat_rd;
    logic iface_enable, master;
    logic wr_dath, rd_dath, wr_stat;
    logic tx_fetch, rx_store;

    assign iface_enable = cfg0_r[sap_pkg::CFG0_IFACE_ENABLE];
    assign master = cfg0_r[sap_pkg::CFG0_MASTER];
    assign wr_dath = WR_I && (ADDR_I == sap_pkg::ADDR_DATH);
    assign rd_dath = RD_I && (ADDR_I == sap_pkg::ADDR_DATH);
    assign wr_stat = WR_I && (ADDR_I == sap_pkg::ADDR_STAT);

    // ==================================================================
    // fractional divider
    logic [14:0] num;
    logic [8:0] den;
    logic [15:0] acc_r;
    logic half_tick;
    assign num = {clkf2_r[6:0], clkf1_r};
    assign den = {clkf2_r[7], clkf0_r};
    // accumulate denominator, wrap at numerator: one tick per half period
    always_ff @(posedge CLK_I) begin
        if (!NRST_I || !iface_enable || !master) begin
            acc_r <= 16'h0000;
        end else if (acc_r + {7'h00, den} >= {1'b0, num}) begin
            acc_r <= acc_r + {7'h00, den} - {1'b0, num};
        end else begin
            acc_r <= acc_r + {7'h00, den};
        end
    end
    assign half_tick = iface_enable && master &&
                       (acc_r + {7'h00, den} >= {1'b0, num});

    // ==================================================================
    // bit clock and word select, master or slave
    logic sck_m_r, ws_m_r, sck_prev_r;
    logic [5:0] bitcnt_r;
    logic sck_cur, ws_cur, rise, fall;
    // master clock toggle and word select counter
    always_ff @(posedge CLK_I) begin
        if (!NRST_I || !iface_enable || !master) begin
            sck_m_r <= 1'b0;
            ws_m_r <= 1'b0;
            bitcnt_r <= 6'h00;
        end else if (half_tick) begin
            sck_m_r <= ~sck_m_r;
            if (sck_m_r) begin
                // falling edge: ws flips before last bit of word
                if (bitcnt_r == {1'b0, words_r} - 6'h01 ||
                        words_r == 5'h00) begin
                    ws_m_r <= ~ws_m_r;
                end
                bitcnt_r <= (bitcnt_r == {1'b0, words_r}) ?
                            6'h00 : bitcnt_r + 6'h01;
            end
        end
    end
    assign sck_cur = master ? sck_m_r : SCK_I;
    assign ws_cur = master ? ws_m_r : WS_I;
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            sck_prev_r <= 1'b0;
        end else begin
            sck_prev_r <= sck_cur;
        end
    end
    assign rise = iface_enable && sck_cur && !sck_prev_r;
    assign fall = iface_enable && !sck_cur && sck_prev_r;

    // ==================================================================
    // transmit shifter: loads at word boundary on falling edge
    logic [15:0] tx_buf_r, tx_sh_r;
    logic [4:0] tx_left_r;
    logic ws_tx_r, tx_bit_r, tx_repeat_r;
    logic tx_word_start;
    assign tx_word_start = fall && (ws_cur != ws_tx_r);
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            ws_tx_r <= 1'b0;
            tx_sh_r <= 16'h0000;
            tx_left_r <= 5'h00;
            tx_bit_r <= 1'b0;
            tx_repeat_r <= 1'b0;
        end else if (fall) begin
            ws_tx_r <= ws_cur;
            if (tx_word_start) begin
                // old word's last bit leaves with the new select level
                tx_sh_r <= tx_buf_r;
                tx_left_r <= 5'h10;
                tx_repeat_r <= cfg0_r[sap_pkg::CFG0_TX_SINGLE_CHANNEL] &&
                               !tx_repeat_r;
                tx_bit_r <= (tx_left_r != 5'h00) ? tx_sh_r[15] :
                            1'b0;
            end else if (tx_left_r != 5'h00) begin
                tx_bit_r <= tx_sh_r[15];
                tx_sh_r <= {tx_sh_r[14:0], 1'b0};
                tx_left_r <= tx_left_r - 5'h01;
            end else begin
                tx_bit_r <= 1'b0;
            end
        end
    end
    // next sample fetched into buffer at each word start, only every second one in tx single-channel mode
    assign tx_fetch = tx_word_start &&
                      !(cfg0_r[sap_pkg::CFG0_TX_SINGLE_CHANNEL] && !tx_repeat_r);

    // ==================================================================
    // receive shifter: samples on rising edge
    logic [15:0] rx_sh_r, rx_sh_nxt, rx_word_r;
    logic [5:0] rx_cnt_r;
    logic ws_rx_r, rx_ch_r;
    // keep only the first sixteen bits of a word
    assign rx_sh_nxt = (rx_cnt_r < 6'h10) ? {rx_sh_r[14:0], SD_RX_I} :
                       rx_sh_r;
    // shift, count, and latch the word when select flips
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            ws_rx_r <= 1'b0;
            rx_sh_r <= 16'h0000;
            rx_cnt_r <= 6'h00;
            rx_ch_r <= 1'b0;
            rx_word_r <= 16'h0000;
        end else if (rise) begin
            ws_rx_r <= ws_cur;
            rx_sh_r <= rx_sh_nxt;
            if (ws_cur != ws_rx_r) begin
                // last bit came with the new level; word is old channel
                rx_cnt_r <= 6'h00;
                rx_ch_r <= ws_rx_r;
                rx_word_r <= (rx_cnt_r >= 6'h0f) ? rx_sh_nxt :
                             (rx_sh_nxt << (6'h0f - rx_cnt_r));
            end else if (rx_cnt_r != 6'h3f) begin
                rx_cnt_r <= rx_cnt_r + 6'h01;
            end
        end
    end
    // word finishes when ws flips; last bit was taken on that same rising edge
    logic rx_done_pend_r;
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            rx_done_pend_r <= 1'b0;
        end else if (rise) begin
            rx_done_pend_r <= (ws_cur != ws_rx_r);
        end
    end
    // store one rise after the flip; mono drops right words
    assign rx_store = rise && rx_done_pend_r &&
                      !(cfg0_r[sap_pkg::CFG0_RX_SINGLE_CHANNEL] && !rx_ch_r ? 1'b0 :
                        cfg0_r[sap_pkg::CFG0_RX_SINGLE_CHANNEL] && rx_ch_r);

    // ==================================================================
    // configuration and data registers
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            cfg0_r <= sap_pkg::CFG0_RST;
            words_r <= sap_pkg::WORDS_RST;
            clkf0_r <= sap_pkg::CLKF0_RST;
            clkf1_r <= sap_pkg::CLKF1_RST;
            clkf2_r <= sap_pkg::CLKF2_RST;
            datl_w_r <= 8'h00;
            dath_w_r <= 8'h00;
        end else if (WR_I) begin
            if (ADDR_I == sap_pkg::ADDR_CFG0) begin
                cfg0_r <= WDATA_I;
            end else if (ADDR_I == sap_pkg::ADDR_CFG1) begin
                words_r <= WDATA_I[4:0];
            end else if (ADDR_I == sap_pkg::ADDR_DATL) begin
                datl_w_r <= WDATA_I;
            end else if (ADDR_I == sap_pkg::ADDR_DATH) begin
                dath_w_r <= WDATA_I;
            end else if (ADDR_I == sap_pkg::ADDR_CLKF0) begin
                clkf0_r <= WDATA_I;
            end else if (ADDR_I == sap_pkg::ADDR_CLKF1) begin
                clkf1_r <= WDATA_I;
            end else if (ADDR_I == sap_pkg::ADDR_CLKF2) begin
                clkf2_r <= WDATA_I;
            end
        end
    end

    // transmit buffer: high write completes the sample
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            tx_buf_r <= 16'h0000;
            tx_full_r <= 1'b0;
            tx_underflow_flag_r <= 1'b0;
            tx_channel_side_r <= 1'b0;
        end else begin
            if (tx_fetch) begin
                tx_channel_side_r <= ~ws_cur;
                if (tx_full_r) begin
                    tx_buf_r <= {dath_w_r, datl_w_r};
                end
            end
            if (wr_dath) begin
                tx_full_r <= 1'b1;
            end else if (tx_fetch) begin
                tx_full_r <= 1'b0;
            end
            if (tx_fetch && !tx_full_r) begin
                tx_underflow_flag_r <= 1'b1;
            end else if (wr_stat) begin
                tx_underflow_flag_r <= WDATA_I[sap_pkg::ST_TX_UNDERFLOW_FLAG];
            end
        end
    end

    // receive data registers: overwrite on overflow
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            rx_data_r <= 16'h0000;
            rx_full_r <= 1'b0;
            rx_overflow_flag_r <= 1'b0;
            rx_channel_side_r <= 1'b0;
        end else begin
            if (rx_store) begin
                rx_data_r <= rx_word_r;
                rx_channel_side_r <= rx_ch_r;
                rx_full_r <= 1'b1;
            end else if (rd_dath) begin
                rx_full_r <= 1'b0;
            end
            if (rx_store && rx_full_r) begin
                rx_overflow_flag_r <= 1'b1;
            end else if (wr_stat) begin
                rx_overflow_flag_r <= WDATA_I[sap_pkg::ST_RX_OVERFLOW_FLAG];
            end
        end
    end

    // done flags: event wins over clear, software may set
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            tx_done_flag_r <= 1'b0;
            rx_done_flag_r <= 1'b0;
        end else begin
            if (tx_fetch) begin
                tx_done_flag_r <= 1'b1;
            end else if (wr_dath) begin
                tx_done_flag_r <= 1'b0;
            end else if (wr_stat) begin
                tx_done_flag_r <= WDATA_I[sap_pkg::ST_TX_DONE_FLAG];
            end
            if (rx_store) begin
                rx_done_flag_r <= 1'b1;
            end else if (rd_dath) begin
                rx_done_flag_r <= 1'b0;
            end else if (wr_stat) begin
                rx_done_flag_r <= WDATA_I[sap_pkg::ST_RX_DONE_FLAG];
            end
        end
    end

    // ==================================================================
    // outputs, all registered
    assign stat_rd = {2'b00, tx_channel_side_r, rx_channel_side_r,
                      tx_underflow_flag_r, rx_overflow_flag_r,
                      tx_done_flag_r, rx_done_flag_r};
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            RDATA_O <= 8'h00;
        end else if (ADDR_I == sap_pkg::ADDR_CFG0) begin
            RDATA_O <= cfg0_r;
        end else if (ADDR_I == sap_pkg::ADDR_CFG1) begin
            RDATA_O <= {3'b000, words_r};
        end else if (ADDR_I == sap_pkg::ADDR_DATL) begin
            RDATA_O <= rx_data_r[7:0];
        end else if (ADDR_I == sap_pkg::ADDR_DATH) begin
            RDATA_O <= rx_data_r[15:8];
        end else if (ADDR_I == sap_pkg::ADDR_CLKF0) begin
            RDATA_O <= clkf0_r;
        end else if (ADDR_I == sap_pkg::ADDR_CLKF1) begin
            RDATA_O <= clkf1_r;
        end else if (ADDR_I == sap_pkg::ADDR_CLKF2) begin
            RDATA_O <= clkf2_r;
        end else if (ADDR_I == sap_pkg::ADDR_STAT) begin
            RDATA_O <= stat_rd;
        end else begin
            RDATA_O <= 8'h00;
        end
    end

    // interrupt, dma triggers and pins
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            IRQ_O <= 1'b0;
            SYS_TX_INT_FLAG_O <= 1'b0;
            SYS_RX_INT_FLAG_O <= 1'b0;
            TX_COMPLETE_TRIGGER_O <= 1'b0;
            RX_COMPLETE_TRIGGER_O <= 1'b0;
            SCK_O <= 1'b0;
            SCK_OE_O <= 1'b0;
            WS_O <= 1'b0;
            WS_OE_O <= 1'b0;
            SD_TX_O <= 1'b0;
        end else begin
            IRQ_O <= (tx_done_flag_r && cfg0_r[sap_pkg::CFG0_TX_DONE_INT_EN] &&
                      SYS_TX_INT_EN_I) ||
                     (rx_done_flag_r && cfg0_r[sap_pkg::CFG0_RX_DONE_INT_EN] &&
                      SYS_RX_INT_EN_I);
            SYS_TX_INT_FLAG_O <= tx_fetch;
            SYS_RX_INT_FLAG_O <= rx_store;
            TX_COMPLETE_TRIGGER_O <= tx_fetch;
            RX_COMPLETE_TRIGGER_O <= rx_store;
            SCK_O <= sck_m_r;
            SCK_OE_O <= iface_enable && master;
            WS_O <= ws_m_r;
            WS_OE_O <= iface_enable && master;
            SD_TX_O <= tx_bit_r;
        end
    end
endmodule : sap_port

// file: sap_port_asserts.sv
// checker for the serial audio port, on top-level ports only
// assumes master mode with the reset divider and one clock
`timescale 1ns/1ps
module sap_asserts (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic SYS_TX_INT_EN_I,
    input wire logic SYS_RX_INT_EN_I,
    input wire logic SYS_TX_INT_FLAG_O,
    input wire logic SYS_RX_INT_FLAG_O,
    input wire logic IRQ_O,
    input wire logic TX_COMPLETE_TRIGGER_O,
    input wire logic RX_COMPLETE_TRIGGER_O,
    input wire logic SCK_O,
    input wire logic SCK_OE_O,
    input wire logic WS_O,
    input wire logic WS_OE_O,
    input wire logic SD_TX_O
);
    // ====================================================
    // clocking and one half bit of 8 or 9 clocks
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);
    sequence s_phase;
        $stable(SCK_O) [*7] ##[1:2] $changed(SCK_O);
    endsequence
    // ====================================================
    // line timing and event checks
    a_oe_pair: assert property (SCK_OE_O == WS_OE_O)
        else $error("clock and word select enables differ");
    a_sck_phase: assert property (SCK_OE_O && $past(SCK_OE_O)
        && $changed(SCK_O) |=> s_phase)
        else $error("bit clock phase length wrong");
    a_ws_low_clk: assert property ($changed(WS_O) |-> !SCK_O)
        else $error("word select moved while clock high");
    a_sd_low_clk: assert property (SCK_OE_O && $past(SCK_OE_O)
        && $changed(SD_TX_O) |-> !SCK_O)
        else $error("serial data moved while clock high");
    a_tx_flag_pair: assert property ($rose(TX_COMPLETE_TRIGGER_O)
        |-> SYS_TX_INT_FLAG_O)
        else $error("tx trigger without system flag");
    a_rx_flag_pair: assert property ($rose(RX_COMPLETE_TRIGGER_O)
        |-> SYS_RX_INT_FLAG_O)
        else $error("rx trigger without system flag");
    a_irq_gated: assert property (IRQ_O |-> $past(SYS_TX_INT_EN_I)
        || $past(SYS_RX_INT_EN_I))
        else $error("interrupt without system enable");
    a_tx_once: assert property (TX_COMPLETE_TRIGGER_O
        |=> !TX_COMPLETE_TRIGGER_O [*8])
        else $error("tx trigger repeated within a word");
endmodule : sap_asserts

bind sap_port sap_asserts u_chk (.CLK_I(CLK_I), .NRST_I(NRST_I),
    .SYS_TX_INT_EN_I(SYS_TX_INT_EN_I), .SYS_RX_INT_EN_I(SYS_RX_INT_EN_I),
    .SYS_TX_INT_FLAG_O(SYS_TX_INT_FLAG_O), .IRQ_O(IRQ_O),
    .SYS_RX_INT_FLAG_O(SYS_RX_INT_FLAG_O), .SCK_O(SCK_O),
    .TX_COMPLETE_TRIGGER_O(TX_COMPLETE_TRIGGER_O), .WS_O(WS_O),
    .RX_COMPLETE_TRIGGER_O(RX_COMPLETE_TRIGGER_O), .SCK_OE_O(SCK_OE_O),
    .WS_OE_O(WS_OE_O), .SD_TX_O(SD_TX_O));

// file: sap_codec.sv
// codec model: captures sent words, serves a fixed word per channel
// assumes bit clock and word select come from the port, slow to clk_i
`timescale 1ns/1ps
module sap_codec #(
    parameter logic [15:0] LEFT_WORD = 16'ha53c,
    parameter logic [15:0] RIGHT_WORD = 16'h5ac3
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sck_i,
    input wire logic ws_i,
    input wire logic sd_i,
    output logic sd_o,
    output logic [15:0] word_o,
    output logic word_ch_o,
    output logic [5:0] word_bits_o,
    output logic word_stb_o
);
    logic sck_d, ws_r, pend, nxt_ch;
    logic [15:0] sh, tx_sh;
    logic [5:0] cnt;
    // ====================================================
    // serial side
    assign sd_o = tx_sh[15];
    // sample on rise, close word on select change, drive on fall
    always_ff @(posedge clk_i) begin
        sck_d <= sck_i;
        word_stb_o <= 1'b0;
        if (!rst_n_i) begin
            {ws_r, pend, nxt_ch, sh, tx_sh, cnt} <= '0;
            {word_o, word_ch_o, word_bits_o} <= '0;
        end else if (sck_i && !sck_d) begin
            ws_r <= ws_i;
            sh <= {sh[14:0], sd_i};
            cnt <= cnt + 6'h01;
            if (ws_i != ws_r) begin
                word_o <= {sh[14:0], sd_i};
                word_ch_o <= ws_r;
                word_bits_o <= cnt + 6'h01;
                word_stb_o <= 1'b1;
                cnt <= 6'h00;
                pend <= 1'b1;
                nxt_ch <= ws_i;
            end
        end else if (!sck_i && sck_d) begin
            pend <= 1'b0;
            if (pend) begin
                tx_sh <= nxt_ch ? RIGHT_WORD : LEFT_WORD;
            end else begin
                tx_sh <= {tx_sh[14:0], ~tx_sh[15]};
            end
        end
    end
endmodule : sap_codec

// file: tb.sv
// testbench: register bus stimulus, codec model on the serial side
// assumes reset divider values and 16-bit words in master mode
`timescale 1ns/1ps
module tb;
    localparam logic [15:0] LW = 16'ha53c;
    localparam logic [15:0] RW = 16'h5ac3;
    logic clk, nrst, wr, rd, stx_en, srx_en, stx_f, srx_f, irq;
    logic tx_trig, rx_trig, sck, sck_oe, ws, ws_oe, sd_rx, sd_tx;
    logic sck_w, ws_w, wstb, wch;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [15:0] w;
    logic [5:0] wbits;
    logic [22:0] q[$];
    int err_count, cmp_count;
    // ====================================================
    // wires with pull-downs, design and codec
    assign sck_w = sck_oe ? sck : 1'b0;
    assign ws_w = ws_oe ? ws : 1'b0;
    sap_port dut (.CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WR_I(wr),
        .RD_I(rd), .WDATA_I(wdata), .RDATA_O(rdata),
        .SYS_TX_INT_EN_I(stx_en), .SYS_RX_INT_EN_I(srx_en),
        .SYS_TX_INT_FLAG_O(stx_f), .SYS_RX_INT_FLAG_O(srx_f), .IRQ_O(irq),
        .TX_COMPLETE_TRIGGER_O(tx_trig), .RX_COMPLETE_TRIGGER_O(rx_trig),
        .SCK_I(sck_w), .SCK_O(sck), .SCK_OE_O(sck_oe), .WS_I(ws_w),
        .WS_O(ws), .WS_OE_O(ws_oe), .SD_RX_I(sd_rx), .SD_TX_O(sd_tx));
    sap_codec #(.LEFT_WORD(LW), .RIGHT_WORD(RW)) codec (.clk_i(clk),
        .rst_n_i(nrst), .sck_i(sck_w), .ws_i(ws_w), .sd_i(sd_tx),
        .sd_o(sd_rx), .word_o(w), .word_ch_o(wch), .word_bits_o(wbits),
        .word_stb_o(wstb));
    // collect finished words
    always @(posedge clk) begin
        if (wstb) begin
            q.push_back({wch, wbits, w});
        end
    end
    // clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ====================================================
    // shared tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        cyc(1);
        addr = a;
        wdata = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        cyc(1);
        addr = a;
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        d = rdata;
    endtask : rd_reg
    task automatic wait_trig(input logic rx);
        int n;
        n = 0;
        cyc(1);
        while ((rx ? rx_trig : tx_trig) !== 1'b1 && n < 2000) begin
            cyc(1);
            n++;
        end
        if (n >= 2000) begin
            err_count++;
            $display("ERROR trigger expected 1 seen 0");
            stop_test();
        end
        chk("sys flag", 16'h0001, 16'(rx ? srx_f : stx_f));
    endtask : wait_trig
    task automatic stop_test();
        $display("checks %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    // ====================================================
    // scenarios
    task automatic t_regs();
        logic [7:0] d;
        logic [7:0] rv [3];
        rv = '{sap_pkg::CLKF0_RST, sap_pkg::CLKF1_RST, sap_pkg::CLKF2_RST};
        for (int i = 0; i < 3; i++) begin
            rd_reg(sap_pkg::ADDR_CLKF0 + 4'(i), d);
            chk("divider reset", 16'(rv[i]), 16'(d));
            wr_reg(sap_pkg::ADDR_CLKF0 + 4'(i), ~rv[i]);
            rd_reg(sap_pkg::ADDR_CLKF0 + 4'(i), d);
            chk("divider rw", {8'h00, ~rv[i]}, 16'(d));
            wr_reg(sap_pkg::ADDR_CLKF0 + 4'(i), rv[i]);
        end
        rd_reg(sap_pkg::ADDR_CFG1, d);
        chk("word size", 16'h000f, 16'(d));
        wr_reg(4'h7, 8'hff);
        rd_reg(4'h7, d);
        chk("unmapped", 16'h0000, 16'(d));
    endtask : t_regs
    task automatic t_tx();
        logic [7:0] d;
        logic [15:0] ex [4];
        int i;
        ex = '{16'hc65b, 16'h7e29, 16'h18e4, 16'h18e4};
        i = -1;
        wr_reg(sap_pkg::ADDR_DATL, 8'h5b);
        wr_reg(sap_pkg::ADDR_DATH, 8'hc6);
        wr_reg(sap_pkg::ADDR_CFG0, 8'h03);
        cyc(1);
        chk("master on", 16'h0001, 16'(sck_oe & ws_oe));
        wait_trig(1'b0);
        rd_reg(sap_pkg::ADDR_STAT, d);
        chk("tx done", 16'h0001, 16'(d[sap_pkg::ST_TX_DONE_FLAG]));
        wr_reg(sap_pkg::ADDR_DATL, 8'h29);
        wr_reg(sap_pkg::ADDR_DATH, 8'h7e);
        rd_reg(sap_pkg::ADDR_STAT, d);
        chk("tx done off", 16'h0000, 16'(d[sap_pkg::ST_TX_DONE_FLAG]));
        wait_trig(1'b0);
        wr_reg(sap_pkg::ADDR_DATL, 8'he4);
        wr_reg(sap_pkg::ADDR_DATH, 8'h18);
        wait_trig(1'b0);
        wait_trig(1'b0);
        rd_reg(sap_pkg::ADDR_STAT, d);
        chk("underflow", 16'h0001, 16'(d[sap_pkg::ST_TX_UNDERFLOW_FLAG]));
        wait_trig(1'b0);
        cyc(40);
        wr_reg(sap_pkg::ADDR_STAT, 8'h00);
        rd_reg(sap_pkg::ADDR_STAT, d);
        chk("underflow off", 16'h0000, 16'(d[sap_pkg::ST_TX_UNDERFLOW_FLAG]));
        wait_trig(1'b0);
        cyc(20);
        foreach (q[k]) begin
            if (q[k][15:0] === ex[0] && i < 0) begin
                i = k;
            end
        end
        if (i < 0) begin
            i = 0;
        end
        for (int k = 0; k < 4; k++) begin
            chk("tx word", ex[k], q[i+k][15:0]);
            chk("tx bits", 16'h0010, 16'(q[i+k][21:16]));
            chk("tx side", 16'(k[0] ^ q[i][22]), 16'(q[i+k][22]));
        end
    endtask : t_tx
    task automatic t_rx();
        logic [7:0] d, lo, hi;
        wait_trig(1'b1);
        rd_reg(sap_pkg::ADDR_DATH, d);
        wr_reg(sap_pkg::ADDR_STAT, 8'h00);
        wait_trig(1'b1);
        rd_reg(sap_pkg::ADDR_STAT, d);
        chk("rx done", 16'h0001, 16'(d[sap_pkg::ST_RX_DONE_FLAG]));
        rd_reg(sap_pkg::ADDR_DATL, lo);
        rd_reg(sap_pkg::ADDR_DATH, hi);
        chk("rx word", d[sap_pkg::ST_RX_CHANNEL_SIDE] ? RW : LW, {hi, lo});
        rd_reg(sap_pkg::ADDR_STAT, d);
        chk("rx done off", 16'h0000, 16'(d[sap_pkg::ST_RX_DONE_FLAG]));
        chk("no overflow", 16'h0000, 16'(d[sap_pkg::ST_RX_OVERFLOW_FLAG]));
        wait_trig(1'b1);
        wait_trig(1'b1);
        rd_reg(sap_pkg::ADDR_STAT, d);
        chk("overflow", 16'h0001, 16'(d[sap_pkg::ST_RX_OVERFLOW_FLAG]));
        wr_reg(sap_pkg::ADDR_CFG0, 8'h07);
        repeat (2) begin
            wait_trig(1'b1);
            rd_reg(sap_pkg::ADDR_STAT, d);
            chk("rx mono side", 16'h0000, 16'(d[sap_pkg::ST_RX_CHANNEL_SIDE]));
        end
    endtask : t_rx
    task automatic t_irq();
        logic [7:0] d;
        wr_reg(sap_pkg::ADDR_CFG0, 8'h83);
        wr_reg(sap_pkg::ADDR_DATH, 8'h3c);
        wait_trig(1'b0);
        cyc(2);
        chk("irq masked", 16'h0000, 16'(irq));
        stx_en = 1'b1;
        cyc(2);
        chk("irq tx", 16'h0001, 16'(irq));
        stx_en = 1'b0;
        wr_reg(sap_pkg::ADDR_CFG0, 8'h43);
        srx_en = 1'b1;
        wait_trig(1'b1);
        rd_reg(sap_pkg::ADDR_DATH, d);
        cyc(2);
        chk("irq idle", 16'h0000, 16'(irq));
        wr_reg(sap_pkg::ADDR_STAT, 8'h01);
        cyc(2);
        chk("irq soft", 16'h0001, 16'(irq));
    endtask : t_irq
    // ====================================================
    // main sequence
    initial begin
        {nrst, wr, rd, stx_en, srx_en, addr, wdata} <= '0;
        err_count = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_regs();
        t_tx();
        t_rx();
        t_irq();
        stop_test();
    end
endmodule : tb
